/* File: shared/swcg_pkg.sv */
// Purpose: constants for the supply warning and clock gating register bank
// Assumes: 8-bit registers on a plain strobe port
// Notes: offsets are register indices on the local port
package swcg_pkg;
    localparam int unsigned ADDR_W = 2;
    localparam int unsigned DATA_W = 8;
    localparam logic [1:0] OFF_WARN = 2'h0;
    localparam logic [1:0] OFF_GATE1 = 2'h1;
    localparam logic [1:0] OFF_GATE2 = 2'h2;
    // warning register fields
    localparam int unsigned BIT_FLAG = 7;
    localparam int unsigned BIT_ACK = 6;
    localparam int unsigned BIT_DET_SEL = 5;
    localparam int unsigned BIT_WARN_SEL = 4;
    localparam int unsigned BIT_IRQ_EN = 3;
    // first gate register fields
    localparam int unsigned BIT_TIMER3 = 7;
    localparam int unsigned BIT_TIMER2 = 6;
    localparam int unsigned BIT_TIMER1 = 5;
    localparam int unsigned BIT_ADC = 4;
    localparam int unsigned BIT_TWO_WIRE = 2;
    localparam int unsigned BIT_SERIAL2 = 1;
    localparam int unsigned BIT_SERIAL1 = 0;
    // second gate register fields
    localparam int unsigned BIT_DEBUG = 7;
    localparam int unsigned BIT_FLASH = 6;
    localparam int unsigned BIT_EXT_IRQ = 5;
    localparam int unsigned BIT_KEYBOARD = 4;
    localparam int unsigned BIT_COMPARATOR = 3;
    localparam int unsigned BIT_RTC = 2;
    localparam int unsigned BIT_SPI = 0;
    // write masks and reset values
    localparam logic [7:0] GATE1_MASK = 8'hf7;
    localparam logic [7:0] GATE2_MASK = 8'hfd;
    localparam logic [7:0] GATE1_RESET = 8'hf7;
    localparam logic [7:0] GATE2_RESET = 8'hfd;
    localparam logic [7:0] READ_NONE = 8'h00;
endpackage : swcg_pkg

/* File: logic/swcg_sync.sv */
// Purpose: two-flop synchroniser for asynchronous levels
// Assumes: one clock, clock enable freezes the chain
// Notes: first stage is read only by the second
`timescale 1ns/100ps
module swcg_sync #(
    parameter int unsigned WIDTH = 1
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            meta_q <= '0;
            sync_out <= '0;
        end else if (clk_en) begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule : swcg_sync

/* File: logic/swcg_regs.sv */
// Purpose: supply warning status/control and peripheral bus clock gate registers
// Assumes: trip indications arrive as digital levels from analog comparators
// Notes: por_b clears the trip selects; rst_b clears the rest but loads GATE1_RESET and GATE2_RESET into the gate registers
//
// The implementer's own choices: the register addresses and the strobed register port.
`timescale 1ns/100ps
module swcg_regs (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic por_b,
    input wire logic clk_en,
    input wire logic [1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [7:0] rdata,
    input wire logic below_warning_low,
    input wire logic below_warning_high,
    output logic detect_trip_select,
    output logic warning_trip_select,
    output logic supply_warning_irq,
    output logic timer_unit_one_clk_en,
    output logic timer_unit_two_clk_en,
    output logic timer_unit_three_clk_en,
    output logic adc_clk_en,
    output logic two_wire_bus_module_clk_en,
    output logic async_serial_one_clk_en,
    output logic async_serial_two_clk_en,
    output logic debug_module_clk_en,
    output logic flash_register_gate_clk_en,
    output logic external_irq_clk_en,
    output logic keyboard_interrupt_module_clk_en,
    output logic analog_comparator_clk_en,
    output logic rtc_bus_clk_en,
    output logic spi_clk_en
);
    logic rst_meta_q;
    logic rst_sync_q;
    logic por_meta_q;
    logic por_sync_q;
    logic [1:0] trip_sync;
    logic warn_low_sync;
    logic warn_high_sync;
    logic flag_q;
    logic flag_d;
    logic flag_set;
    logic flag_hold;
    logic irq_en_q;
    logic irq_en_d;
    logic det_sel_q;
    logic det_sel_d;
    logic warn_sel_q;
    logic warn_sel_d;
    logic sel_wr_ok;
    logic [7:0] gate1_q;
    logic [7:0] gate1_d;
    logic [7:0] gate1_wr;
    logic [7:0] gate2_q;
    logic [7:0] gate2_d;
    logic [7:0] gate2_wr;
    logic [7:0] gate1_view;
    logic [7:0] gate2_view;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic warn_present;
    logic bus_live;
    logic wr_warn;
    logic wr_gate1;
    logic wr_gate2;
    logic rd_live;
    logic wr_ack_bit;
    logic wr_det_bit;
    logic wr_warn_bit;
    logic wr_irq_bit;
    logic ack_clear;
    logic [7:0] warn_view;

    // reset release through two flops
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    always_ff @(posedge clock or negedge por_b) begin
        if (!por_b) begin
            por_meta_q <= 1'b0;
            por_sync_q <= 1'b0;
        end else begin
            por_meta_q <= 1'b1;
            por_sync_q <= por_meta_q;
        end
    end

    // comparator trip levels from the analog side
    swcg_sync #(
        .WIDTH(2)
    ) u_trip_sync (
        .clock(clock),
        .rst_b(rst_sync_q),
        .clk_en(clk_en),
        .async_in({below_warning_high, below_warning_low}),
        .sync_out(trip_sync)
    );

    // name the synchronised trip levels
    assign warn_low_sync = trip_sync[0];
    assign warn_high_sync = trip_sync[1];

    // selected warning threshold
    assign warn_present = warn_sel_q ? warn_high_sync : warn_low_sync;

    // bus qualifiers; no write lands before the reset sync completes
    assign bus_live = clk_en && rst_sync_q;
    assign wr_warn = bus_live && wr_stb && (addr == swcg_pkg::OFF_WARN);
    assign wr_gate1 = bus_live && wr_stb && (addr == swcg_pkg::OFF_GATE1);
    assign wr_gate2 = bus_live && wr_stb && (addr == swcg_pkg::OFF_GATE2);
    assign rd_live = clk_en && rd_stb;

    // write data fields of the warning register
    assign wr_ack_bit = wdata[swcg_pkg::BIT_ACK];
    assign wr_det_bit = wdata[swcg_pkg::BIT_DET_SEL];
    assign wr_warn_bit = wdata[swcg_pkg::BIT_WARN_SEL];
    assign wr_irq_bit = wdata[swcg_pkg::BIT_IRQ_EN];

    // ack only takes effect with the warning gone
    assign ack_clear = wr_warn && wr_ack_bit && !warn_present;

    // set wins over ack in the same cycle
    assign flag_set = warn_present;
    assign flag_hold = flag_q && !ack_clear;
    assign flag_d = flag_set || flag_hold;

    // next values of the control bits
    assign irq_en_d = wr_warn ? wr_irq_bit : irq_en_q;
    assign sel_wr_ok = wr_warn && por_sync_q;
    assign det_sel_d = sel_wr_ok ? wr_det_bit : det_sel_q;
    assign warn_sel_d = sel_wr_ok ? wr_warn_bit : warn_sel_q;

    // first gate write value; bit 3 stays zero
    always_comb begin
        gate1_wr = swcg_pkg::READ_NONE;
        gate1_wr[swcg_pkg::BIT_TIMER3] = wdata[swcg_pkg::BIT_TIMER3];
        gate1_wr[swcg_pkg::BIT_TIMER2] = wdata[swcg_pkg::BIT_TIMER2];
        gate1_wr[swcg_pkg::BIT_TIMER1] = wdata[swcg_pkg::BIT_TIMER1];
        gate1_wr[swcg_pkg::BIT_ADC] = wdata[swcg_pkg::BIT_ADC];
        gate1_wr[swcg_pkg::BIT_TWO_WIRE] = wdata[swcg_pkg::BIT_TWO_WIRE];
        gate1_wr[swcg_pkg::BIT_SERIAL2] = wdata[swcg_pkg::BIT_SERIAL2];
        gate1_wr[swcg_pkg::BIT_SERIAL1] = wdata[swcg_pkg::BIT_SERIAL1];
    end

    // second gate write value; bit 1 stays zero
    always_comb begin
        gate2_wr = swcg_pkg::READ_NONE;
        gate2_wr[swcg_pkg::BIT_DEBUG] = wdata[swcg_pkg::BIT_DEBUG];
        gate2_wr[swcg_pkg::BIT_FLASH] = wdata[swcg_pkg::BIT_FLASH];
        gate2_wr[swcg_pkg::BIT_EXT_IRQ] = wdata[swcg_pkg::BIT_EXT_IRQ];
        gate2_wr[swcg_pkg::BIT_KEYBOARD] = wdata[swcg_pkg::BIT_KEYBOARD];
        gate2_wr[swcg_pkg::BIT_COMPARATOR] = wdata[swcg_pkg::BIT_COMPARATOR];
        gate2_wr[swcg_pkg::BIT_RTC] = wdata[swcg_pkg::BIT_RTC];
        gate2_wr[swcg_pkg::BIT_SPI] = wdata[swcg_pkg::BIT_SPI];
    end

    // gate next values
    assign gate1_d = wr_gate1 ? gate1_wr : gate1_q;
    assign gate2_d = wr_gate2 ? gate2_wr : gate2_q;

    // warning flag
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            flag_q <= 1'b0;
        end else if (!rst_sync_q) begin
            flag_q <= 1'b0;
        end else if (clk_en) begin
            flag_q <= flag_d;
        end
    end

    // interrupt enable clears on rst_b; por_b alone leaves it
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            irq_en_q <= 1'b0;
        end else if (!rst_sync_q) begin
            irq_en_q <= 1'b0;
        end else begin
            irq_en_q <= irq_en_d;
        end
    end

    // detect select survives ordinary resets, cleared only by power-on
    always_ff @(posedge clock or negedge por_b) begin
        if (!por_b) begin
            det_sel_q <= 1'b0;
        end else begin
            det_sel_q <= det_sel_d;
        end
    end

    // warning select likewise
    always_ff @(posedge clock or negedge por_b) begin
        if (!por_b) begin
            warn_sel_q <= 1'b0;
        end else begin
            warn_sel_q <= warn_sel_d;
        end
    end

    // first gate register
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            gate1_q <= swcg_pkg::GATE1_RESET;
        end else if (!rst_sync_q) begin
            gate1_q <= swcg_pkg::GATE1_RESET;
        end else begin
            gate1_q <= gate1_d;
        end
    end

    // second gate register
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            gate2_q <= swcg_pkg::GATE2_RESET;
        end else if (!rst_sync_q) begin
            gate2_q <= swcg_pkg::GATE2_RESET;
        end else begin
            gate2_q <= gate2_d;
        end
    end

    // read view; ack and low bits read zero
    always_comb begin
        warn_view = swcg_pkg::READ_NONE;
        warn_view[swcg_pkg::BIT_FLAG] = flag_q;
        warn_view[swcg_pkg::BIT_DET_SEL] = det_sel_q;
        warn_view[swcg_pkg::BIT_WARN_SEL] = warn_sel_q;
        warn_view[swcg_pkg::BIT_IRQ_EN] = irq_en_q;
    end

    // first gate read view; bit 3 reads zero
    always_comb begin
        gate1_view = swcg_pkg::READ_NONE;
        gate1_view[swcg_pkg::BIT_TIMER3] = gate1_q[swcg_pkg::BIT_TIMER3];
        gate1_view[swcg_pkg::BIT_TIMER2] = gate1_q[swcg_pkg::BIT_TIMER2];
        gate1_view[swcg_pkg::BIT_TIMER1] = gate1_q[swcg_pkg::BIT_TIMER1];
        gate1_view[swcg_pkg::BIT_ADC] = gate1_q[swcg_pkg::BIT_ADC];
        gate1_view[swcg_pkg::BIT_TWO_WIRE] = gate1_q[swcg_pkg::BIT_TWO_WIRE];
        gate1_view[swcg_pkg::BIT_SERIAL2] = gate1_q[swcg_pkg::BIT_SERIAL2];
        gate1_view[swcg_pkg::BIT_SERIAL1] = gate1_q[swcg_pkg::BIT_SERIAL1];
    end

    // second gate read view; bit 1 reads zero
    always_comb begin
        gate2_view = swcg_pkg::READ_NONE;
        gate2_view[swcg_pkg::BIT_DEBUG] = gate2_q[swcg_pkg::BIT_DEBUG];
        gate2_view[swcg_pkg::BIT_FLASH] = gate2_q[swcg_pkg::BIT_FLASH];
        gate2_view[swcg_pkg::BIT_EXT_IRQ] = gate2_q[swcg_pkg::BIT_EXT_IRQ];
        gate2_view[swcg_pkg::BIT_KEYBOARD] = gate2_q[swcg_pkg::BIT_KEYBOARD];
        gate2_view[swcg_pkg::BIT_COMPARATOR] = gate2_q[swcg_pkg::BIT_COMPARATOR];
        gate2_view[swcg_pkg::BIT_RTC] = gate2_q[swcg_pkg::BIT_RTC];
        gate2_view[swcg_pkg::BIT_SPI] = gate2_q[swcg_pkg::BIT_SPI];
    end

    // read select
    always_comb begin
        case (addr)
            swcg_pkg::OFF_WARN: begin
                rdata_d = warn_view;
            end
            swcg_pkg::OFF_GATE1: begin
                rdata_d = gate1_view;
            end
            swcg_pkg::OFF_GATE2: begin
                rdata_d = gate2_view;
            end
            default: begin
                rdata_d = swcg_pkg::READ_NONE;
            end
        endcase
    end

    // read data valid from the cycle after the strobe until the next clock with clk_en high
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rdata_q <= swcg_pkg::READ_NONE;
        end else if (rd_live) begin
            rdata_q <= rdata_d;
        end else if (clk_en) begin
            rdata_q <= swcg_pkg::READ_NONE;
        end
    end

    assign rdata = rdata_q;

    // warning side outputs
    assign detect_trip_select = det_sel_q;
    assign warning_trip_select = warn_sel_q;
    assign supply_warning_irq = flag_q && irq_en_q;

    // timer units and converter
    assign timer_unit_three_clk_en = gate1_q[swcg_pkg::BIT_TIMER3];
    assign timer_unit_two_clk_en = gate1_q[swcg_pkg::BIT_TIMER2];
    assign timer_unit_one_clk_en = gate1_q[swcg_pkg::BIT_TIMER1];
    assign adc_clk_en = gate1_q[swcg_pkg::BIT_ADC];

    // two-wire and serial modules
    assign two_wire_bus_module_clk_en = gate1_q[swcg_pkg::BIT_TWO_WIRE];
    assign async_serial_two_clk_en = gate1_q[swcg_pkg::BIT_SERIAL2];
    assign async_serial_one_clk_en = gate1_q[swcg_pkg::BIT_SERIAL1];

    // debug and flash registers
    assign debug_module_clk_en = gate2_q[swcg_pkg::BIT_DEBUG];
    assign flash_register_gate_clk_en = gate2_q[swcg_pkg::BIT_FLASH];

    // pin interrupt, keyboard, comparators, counter and spi
    assign external_irq_clk_en = gate2_q[swcg_pkg::BIT_EXT_IRQ];
    assign keyboard_interrupt_module_clk_en = gate2_q[swcg_pkg::BIT_KEYBOARD];
    assign analog_comparator_clk_en = gate2_q[swcg_pkg::BIT_COMPARATOR];
    assign rtc_bus_clk_en = gate2_q[swcg_pkg::BIT_RTC];
    assign spi_clk_en = gate2_q[swcg_pkg::BIT_SPI];
endmodule : swcg_regs

/* File: bench/swcg_regs_properties.sv */
// Purpose: port checks for swcg_regs
// Assumes: driver keeps the strobe bus rules
// Notes: bind at file foot
`timescale 1ns/100ps
module swcg_props (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic [1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire logic [7:0] rdata,
    input wire logic below_warning_low,
    input wire logic detect_trip_select,
    input wire logic warning_trip_select,
    input wire logic supply_warning_irq,
    input wire logic timer_unit_one_clk_en,
    input wire logic timer_unit_three_clk_en,
    input wire logic debug_module_clk_en,
    input wire logic analog_comparator_clk_en
);
    wire logic wr_w = wr_stb && clk_en && addr == 2'h0;
    wire logic wr_g1 = wr_stb && clk_en && addr == 2'h1;
    wire logic wr_g2 = wr_stb && clk_en && addr == 2'h2;
    wire logic rd_w = rd_stb && clk_en && addr == 2'h0;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    property p_tmr; wr_g1 |=> timer_unit_three_clk_en == $past(wdata[7]); endproperty
    a_tmr: assert property (p_tmr) else $error("timer gate");
    property p_hold; !wr_g1 [*2] |=> $stable(timer_unit_one_clk_en); endproperty
    a_hold: assert property (p_hold) else $error("gate drift");
    property p_dbg; wr_g2 |=> debug_module_clk_en == $past(wdata[7]); endproperty
    a_dbg: assert property (p_dbg) else $error("debug gate");
    property p_cmp; wr_g2 |=> analog_comparator_clk_en == $past(wdata[3]); endproperty
    a_cmp: assert property (p_cmp) else $error("comparator gate");
    property p_sel;
        wr_w |=> {detect_trip_select, warning_trip_select} == $past(wdata[5:4]);
    endproperty
    a_sel: assert property (p_sel) else $error("trip selects");
    property p_irq; wr_w && !wdata[3] |=> !supply_warning_irq; endproperty
    a_irq: assert property (p_irq) else $error("irq while disabled");
    property p_rsv; rd_w |=> rdata[6] == 1'b0 && rdata[2:0] == 3'h0; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits");
    property p_flag;
        below_warning_low [*4] ##0 (rd_w && !warning_trip_select) |=> rdata[7];
    endproperty
    a_flag: assert property (p_flag) else $error("flag not set");
endmodule : swcg_props
bind swcg_regs swcg_props u_props (.*);

/* File: bench/testbench.sv */
// Purpose: self-checking bench for swcg_regs
// Assumes: strobes driven by nonblocking writes after rising edges
// Notes: model kept in m1, m2, mw and mflag
`timescale 1ns/100ps
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin failures++; \
    $display("[ERR] %s exp %h got %h", n, e, s); end end
module testbench;
    logic clock = 0, rst_b = 0, por_b = 0, clk_en = 1, wr_stb = 0, rd_stb = 0, mflag;
    logic below_warning_low = 0, below_warning_high = 0;
    logic [1:0] addr = 2'h0, a;
    logic [7:0] wdata = 8'h00, rdata, g1v, g2v, m1, m2, mw, d;
    logic detect_trip_select, warning_trip_select, supply_warning_irq, adc_clk_en;
    logic timer_unit_one_clk_en, timer_unit_two_clk_en, timer_unit_three_clk_en;
    logic two_wire_bus_module_clk_en, async_serial_one_clk_en, async_serial_two_clk_en;
    logic debug_module_clk_en, flash_register_gate_clk_en, external_irq_clk_en;
    logic keyboard_interrupt_module_clk_en, analog_comparator_clk_en, rtc_bus_clk_en, spi_clk_en;
    int failures = 0, tests_run = 0;
    int unsigned seed = 32;
    swcg_regs dut (.*);
    assign g1v = {timer_unit_three_clk_en, timer_unit_two_clk_en, timer_unit_one_clk_en,
        adc_clk_en, 1'b0, two_wire_bus_module_clk_en, async_serial_two_clk_en,
        async_serial_one_clk_en};
    assign g2v = {debug_module_clk_en, flash_register_gate_clk_en, external_irq_clk_en,
        keyboard_interrupt_module_clk_en, analog_comparator_clk_en, rtc_bus_clk_en, 1'b0,
        spi_clk_en};
    initial forever #25 clock = ~clock;
    function automatic int unsigned rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic logic [7:0] exp_rd(input int r);
        return r == 0 ? mw | {mflag, 7'h00} : r == 1 ? m1 : r == 2 ? m2 : 8'h00;
    endfunction : exp_rd
    task automatic wr(input logic [1:0] r, input logic [7:0] v);
        addr <= r;
        wdata <= v;
        wr_stb <= 1'b1;
        @(posedge clock);
        wr_stb <= 1'b0;
        @(posedge clock);
    endtask : wr
    task automatic rd(input logic [1:0] r, output logic [7:0] v);
        addr <= r;
        rd_stb <= 1'b1;
        @(posedge clock);
        rd_stb <= 1'b0;
        #1 v = rdata;
        @(posedge clock);
    endtask : rd
    task automatic mwr(input logic [1:0] r, input logic [7:0] v);
        wr(r, v);
        if (r == 2'h0 && v[6] && !(mw[4] ? below_warning_high : below_warning_low)) begin
            mflag = 1'b0;
        end
        if (r == 2'h0) mw = v & 8'h38;
        if (r == 2'h1) m1 = v & 8'hf7;
        if (r == 2'h2) m2 = v & 8'hfd;
    endtask : mwr
    task automatic check_all();
        logic [7:0] v;
        `CHK("gate1", m1, g1v)
        `CHK("gate2", m2, g2v)
        `CHK("selects", mw[5:4], {detect_trip_select, warning_trip_select})
        `CHK("irq", mflag & mw[3], supply_warning_irq)
        for (int r = 0; r < 4; r++) begin
            rd(2'(r), v);
            `CHK("read", exp_rd(r), v)
        end
    endtask : check_all
    task automatic do_reset(input logic por);
        rst_b <= 1'b0;
        por_b <= !por;
        repeat (2) @(posedge clock);
        rst_b <= 1'b1;
        por_b <= 1'b1;
        repeat (3) @(posedge clock);
        m1 = 8'hf7;
        m2 = 8'hfd;
        mflag = 1'b0;
        mw = por ? 8'h00 : mw & 8'h30;
    endtask : do_reset
    task automatic complete_run();
        $display("checks %0d errors %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : complete_run
    initial begin
        repeat (3000) @(posedge clock);
        failures++;
        complete_run();
    end
    initial begin
        do_reset(1'b1);
        check_all();
        repeat (24) begin
            d = 8'(rnd());
            a = 2'(rnd());
            if (a == 2'h0 && d[5] && !d[4]) d[5] = 1'b0;
            mwr(a, d);
            check_all();
        end
        clk_en <= 1'b0;
        wr(2'h1, ~m1);
        clk_en <= 1'b1;
        check_all();
        mwr(2'h0, 8'h18);
        below_warning_high <= 1'b1;
        repeat (5) @(posedge clock);
        mflag = 1'b1;
        check_all();
        mwr(2'h0, 8'h58);
        check_all();
        below_warning_high <= 1'b0;
        repeat (5) @(posedge clock);
        check_all();
        mwr(2'h0, 8'h58);
        check_all();
        mwr(2'h0, 8'h08);
        below_warning_low <= 1'b1;
        repeat (5) @(posedge clock);
        mflag = 1'b1;
        mwr(2'h0, 8'h00);
        check_all();
        below_warning_low <= 1'b0;
        mwr(2'h0, 8'h38);
        do_reset(1'b0);
        check_all();
        below_warning_high <= 1'b1;
        do_reset(1'b0);
        repeat (3) @(posedge clock);
        mflag = 1'b1;
        check_all();
        below_warning_high <= 1'b0;
        do_reset(1'b1);
        check_all();
        complete_run();
    end
endmodule : testbench
